// [rtl/bus_buffer_defs.svh]
// Notes on behaviour
// - all eight data lines pass unchanged
// - lowest terminal is lsb, highest msb
// - one direction for the whole bus
// - direction: fixed out, fixed in, host line
// - host line high drives terminals, low host
// - unset direction selector means input
// - indicator lit while data line low
// - disabled output leaves terminals pulled high
// - undriven terminal reads high at host
// - stop, failure, pump can disable buffers
// - always setting ignores stop, failure, pump
// - permitted setting follows outputs-permitted signal
// - pump mode needs healthy pump too
`ifndef BUS_BUFFER_DEFS_SVH
`define BUS_BUFFER_DEFS_SVH
`define DATA_WIDTH 8
`define ADDR_CONFIG 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_HOST_OUT 4'h8
`define ADDR_HOST_IN 4'hC
`define CFG_DIR_LSB 0
`define CFG_EN_BIT 2
`define CFG_SRC_BIT 3
`define CFG_STOP_BIT 4
`define CFG_RESET 8'h00
`endif

// [rtl/bus_buffer_pkg.sv]
package bus_buffer_pkg;
    typedef enum logic [1:0] {
        dir_unset = 2'b00,
        dir_out = 2'b01,
        dir_host = 2'b10,
        dir_in = 2'b11
    } dir_sel_e;
    typedef logic [7:0] data_t;
endpackage : bus_buffer_pkg

// [rtl/bus_buffer_if.sv]
interface bus_buffer_if;
    logic [1:0] dir_sel;
    logic en_always;
    logic src_pump;
    logic stop_used;
    logic [7:0] host_out;
    logic host_dir;
    logic stop_active;
    logic fail_active;
    logic pump_ok;
    logic [7:0] term_in;
    logic [7:0] host_in;
    logic [7:0] term_out;
    logic [7:0] term_oe;
    logic [7:0] led_n;
    logic permitted;
    modport core(input dir_sel, en_always, src_pump, stop_used, host_out,
        host_dir, stop_active, fail_active, pump_ok, term_in,
        output host_in, term_out, term_oe, led_n, permitted);
    modport top(output dir_sel, en_always, src_pump, stop_used, host_out,
        host_dir, stop_active, fail_active, pump_ok, term_in,
        input host_in, term_out, term_oe, led_n, permitted);
endinterface : bus_buffer_if

// [rtl/buffer_core.sv]
module buffer_core (
    bus_buffer_if.core b
);
    import bus_buffer_pkg::*;
    wire permitted_w;
    wire enabled_w;
    wire to_term_w;
    wire drive_w;
    // outputs-permitted from failure, optional stop, optional pump
    assign permitted_w = !b.fail_active && !(b.stop_used && b.stop_active)
        && (!b.src_pump || b.pump_ok);
    assign enabled_w = b.en_always || permitted_w;
    // one direction for all bits; unset means input
    assign to_term_w = (b.dir_sel == dir_out) ||
        ((b.dir_sel == dir_host) && b.host_dir);
    assign drive_w = enabled_w && to_term_w;
    assign b.permitted = permitted_w;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            // bit 0 is lowest terminal, bit 7 highest
            assign b.term_out[i] = b.host_out[i];
            assign b.term_oe[i] = drive_w;
            // released line pulls high into the host
            assign b.host_in[i] = (!to_term_w && enabled_w) ?
                b.term_in[i] : 1'b1;
            assign b.led_n[i] = drive_w ? b.host_out[i] :
                b.term_in[i];
        end
    endgenerate
endmodule : buffer_core

// [rtl/bus_buffer_top.sv]
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "bus_buffer_defs.svh"
module bus_buffer_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic host_dir,
    input wire logic stop_active,
    input wire logic fail_active,
    input wire logic pump_ok,
    input wire logic [7:0] term_in,
    output bus_buffer_pkg::data_t term_out,
    output bus_buffer_pkg::data_t term_oe,
    output bus_buffer_pkg::data_t led_n,
    output logic permitted
);
    import bus_buffer_pkg::*;
    bus_buffer_if b ();
    logic [7:0] cfg_ff;
    logic [7:0] host_out_ff;
    logic [7:0] host_in_ff;
    logic [7:0] term_out_ff;
    logic [7:0] term_oe_ff;
    logic [7:0] led_n_ff;
    logic permitted_ff;
    logic aw_ff;
    logic w_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    ////////////////////////////////////////////////////////////////////
    assign b.dir_sel = cfg_ff[`CFG_DIR_LSB+1:`CFG_DIR_LSB];
    assign b.en_always = cfg_ff[`CFG_EN_BIT];
    assign b.src_pump = cfg_ff[`CFG_SRC_BIT];
    assign b.stop_used = cfg_ff[`CFG_STOP_BIT];
    assign b.host_out = host_out_ff;
    assign b.host_dir = host_dir;
    assign b.stop_active = stop_active;
    assign b.fail_active = fail_active;
    assign b.pump_ok = pump_ok;
    assign b.term_in = term_in;
    buffer_core u_core (
        .b(b.core)
    );
    ////////////////////////////////////////////////////////////////////
    // write path
    wire aw_hs = s_axi_awvalid && !aw_ff && !bvalid_ff;
    wire w_hs = s_axi_wvalid && !w_ff && !bvalid_ff;
    wire aw_have = aw_ff || aw_hs;
    wire w_have = w_ff || w_hs;
    wire [3:0] wa = aw_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wd = w_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] ws = w_ff ? wstrb_ff : s_axi_wstrb;
    wire do_wr = aw_have && w_have && !bvalid_ff;
    wire wr_cfg = do_wr && (wa == `ADDR_CONFIG) && ws[0];
    wire wr_out = do_wr && (wa == `ADDR_HOST_OUT) && ws[0];
    wire wr_ok = (wa == `ADDR_CONFIG) || (wa == `ADDR_HOST_OUT);
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            cfg_ff <= `CFG_RESET;
            host_out_ff <= 8'hFF;
        end else begin
            aw_ff <= do_wr ? 1'b0 : aw_have;
            w_ff <= do_wr ? 1'b0 : w_have;
            if (aw_hs) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (wr_cfg) begin
                cfg_ff <= {3'h0, wd[4:0]};
            end
            if (wr_out) begin
                host_out_ff <= wd[7:0];
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    ////////////////////////////////////////////////////////////////////
    // read path
    wire ar_hs = s_axi_arvalid && !rvalid_ff;
    wire [7:0] status_w = {led_n_ff[0], 2'h0, permitted_ff, 1'b0,
        pump_ok, fail_active, stop_active};
    wire [31:0] rd_mux =
        (s_axi_araddr == `ADDR_CONFIG) ? {24'h0, cfg_ff} :
        (s_axi_araddr == `ADDR_STATUS) ? {24'h0, status_w} :
        (s_axi_araddr == `ADDR_HOST_OUT) ? {24'h0, host_out_ff} :
        (s_axi_araddr == `ADDR_HOST_IN) ? {24'h0, host_in_ff} : 32'h0;
    wire rd_ok = (s_axi_araddr[1:0] == 2'h0);
    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'h0;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    ////////////////////////////////////////////////////////////////////
    // registered pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_in_ff <= 8'hFF;
            term_out_ff <= 8'hFF;
            term_oe_ff <= 8'h00;
            led_n_ff <= 8'hFF;
            permitted_ff <= 1'b0;
        end else begin
            host_in_ff <= b.host_in;
            term_out_ff <= b.term_out;
            term_oe_ff <= b.term_oe;
            led_n_ff <= b.led_n;
            permitted_ff <= b.permitted;
        end
    end
    assign term_out = term_out_ff;
    assign term_oe = term_oe_ff;
    assign led_n = led_n_ff;
    assign permitted = permitted_ff;
endmodule : bus_buffer_top

// [sim/term_side_model.sv]
module term_side_model (
    input wire logic [7:0] term_out,
    input wire logic [7:0] term_oe,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] term_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven lines float to the pull-up level
    assign term_in = (term_oe & term_out) | (~term_oe & (ext_val | ~ext_en));
endmodule : term_side_model

// [sim/bus_buffer_monitor.sv]
module bus_buffer_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic fail_active,
    input wire logic [7:0] term_in,
    input wire bus_buffer_pkg::data_t term_oe,
    input wire bus_buffer_pkg::data_t led_n,
    input wire logic permitted
);
    import bus_buffer_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_oe_uniform: assert property (term_oe == 8'h00 || term_oe == 8'hFF)
        else $error("direction split across bits");
    chk_fail_blocks: assert property (fail_active |=> !permitted)
        else $error("permitted during failure");
    chk_input_led: assert property (term_oe == 8'h00 ##1
        term_oe == 8'h00 ##1 term_oe == 8'h00 |-> led_n == $past(term_in))
        else $error("indicator not following input line");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped");
    chk_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
endmodule : bus_buffer_monitor
bind bus_buffer_top bus_buffer_monitor bus_buffer_monitor_inst (.aclk,
    .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .fail_active,
    .term_in, .term_oe, .led_n, .permitted);

// [sim/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_buffer_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic host_dir = 0, stop_active = 0, fail_active = 0, pump_ok = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, permitted, perm, en, dout, ta, tw, tb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] term_in, ext_val = 8'hFF, ext_en = 0, hdat, oe, line;
    logic [4:0] cfg;
    data_t term_out, term_oe, led_n;
    int fails = 0, num_checks = 0, i, k;
    bus_buffer_top bus_buffer_top_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_dir,
        .stop_active, .fail_active, .pump_ok, .term_in, .term_out, .term_oe,
        .led_n, .permitted);
    term_side_model term_side_model_inst (.term_out, .term_oe, .ext_val,
        .ext_en, .term_in);
    initial forever #12.5 aclk = ~aclk;
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic rd, input logic [3:0] a, input data_t d);
        @(posedge aclk);
        if (rd) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        else {s_axi_awaddr, s_axi_wdata[7:0]} <= {a, d};
        if (!rd) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ta = rd ? s_axi_arready : s_axi_awready;
            tw = s_axi_wready;
            tb = rd ? s_axi_rvalid : s_axi_bvalid;
            {resp, rd_v} = rd ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
            @(posedge aclk);
            if (ta && rd) s_axi_arvalid <= 0;
            if (ta && !rd) s_axi_awvalid <= 0;
            if (tw && !rd) s_axi_wvalid <= 0;
            if (tb) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (i == 40) begin
            fails++;
            wrap_up();
        end
    endtask : xfer
    initial begin
        void'($urandom(3427));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        xfer(1, 4'h0, 0);
        chk(rd_v, 0);
        chk(term_oe, 8'h00);
        xfer(0, 4'h1, 0);
        chk(resp, 2'h2);
        for (k = 0; k < 64; k++) begin
            cfg = 5'($urandom);
            hdat = 8'($urandom);
            xfer(0, 4'h8, hdat);
            xfer(0, 4'h0, {3'h0, cfg});
            {host_dir, stop_active, fail_active, pump_ok} <= 4'($urandom);
            {ext_val, ext_en} <= 16'($urandom);
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            perm = !fail_active && (!cfg[3] || pump_ok);
            perm = perm && (!cfg[4] || !stop_active);
            en = cfg[2] || perm;
            dout = cfg[1:0] == 2'd1 || (cfg[1:0] == 2'd2 && host_dir);
            oe = (en && dout) ? 8'hFF : 8'h00;
            line = oe ? hdat : (ext_val | ~ext_en);
            chk(permitted, perm);
            chk(term_oe, oe);
            chk(term_out, hdat);
            chk(led_n, line);
            @(posedge aclk);
            xfer(1, 4'h4, 0);
            chk(rd_v[4], perm);
            if (!dout) xfer(1, 4'hC, 0);
            if (!dout) chk(rd_v, en ? line : 8'hFF);
        end
        wrap_up();
    end
endmodule : testbench
